// ===== core/scl_pkg.sv
// Shared constants and types for the channel clock and line configuration.
package scl_pkg;

   // Register placement: per-channel byte offset, channel stride.
   localparam logic [11:0] CFG_BASE_OFFSET = 12'h15c;
   localparam logic [11:0] CFG_CHANNEL_STRIDE = 12'h080;
   localparam int NUM_CHANNELS = 4;

   // Field positions inside channel_clock_line_config.
   localparam int RX_INV_BIT = 13;
   localparam int TX_INV_BIT = 12;
   localparam int RCS_LSB = 10;
   localparam int TCS_LSB = 7;
   localparam int BCS_LSB = 4;
   localparam int RTS_CLK_BIT = 3;
   localparam int MODE_LSB = 0;

   // Writable bits (31:22 reserved, read as zero) and reset value.
   localparam logic [31:0] CFG_WRITE_MASK = 32'h003fffff;
   localparam logic [31:0] CFG_RESET = 32'h00000007;

   // Receiver clock source codes.
   localparam logic [1:0] RCS_BAUD = 2'h0;
   localparam logic [1:0] RCS_RX_LINE = 2'h1;
   localparam logic [1:0] RCS_DPLL = 2'h2;

   // Transmitter clock source codes.
   localparam logic [2:0] TCS_BAUD = 3'h0;
   localparam logic [2:0] TCS_RX_LINE = 3'h1;
   localparam logic [2:0] TCS_TX_LINE = 3'h2;
   localparam logic [2:0] TCS_DPLL = 3'h3;
   localparam logic [2:0] TCS_BAUD_DIV16 = 3'h4;

   // Baud generator clock source codes.
   localparam logic [2:0] BCS_OSC1 = 3'h0;
   localparam logic [2:0] BCS_OSC2 = 3'h1;
   localparam logic [2:0] BCS_OSC3 = 3'h2;
   localparam logic [2:0] BCS_RX_LINE = 3'h3;
   localparam logic [2:0] BCS_TX_LINE = 3'h4;

   // Oscillator nominal rates in Hz.
   localparam int OSC1_HZ = 14745600;
   localparam int OSC2_HZ = 24000000;
   localparam int OSC3_HZ = 10000000;

   // Baud output divided by 16: toggle every 8 rising edges.
   localparam logic [2:0] DIV16_HALF_LAST = 3'h7;

   // Transceiver mode codes.
   localparam logic [2:0] MODE_DEFAULT_V11 = 3'h0;
   localparam logic [2:0] MODE_EIA530A = 3'h1;
   localparam logic [2:0] MODE_EIA530 = 3'h2;
   localparam logic [2:0] MODE_X21 = 3'h3;
   localparam logic [2:0] MODE_V35 = 3'h4;
   localparam logic [2:0] MODE_EIA449 = 3'h5;
   localparam logic [2:0] MODE_V28 = 3'h6;
   localparam logic [2:0] MODE_HIGH_Z = 3'h7;

   // Serial word framing.
   localparam logic [4:0] WORD_LAST_BIT = 5'h1f;

   // Sampled pin vector positions.
   localparam int PIN_OSC1 = 0;
   localparam int PIN_OSC2 = 1;
   localparam int PIN_OSC3 = 2;
   localparam int PIN_RX_CLK = 3;
   localparam int PIN_TX_CLK = 4;
   localparam int PIN_RXD = 5;
   localparam int PIN_COUNT = 6;

   // Decoded configuration fields.
   typedef struct packed {
      logic rxClockInvert;
      logic txClockInvert;
      logic [1:0] receiverClockSelect;
      logic [2:0] transmitterClockSelect;
      logic [2:0] baudGenClockSelect;
      logic txClockOnRts;
      logic [2:0] transceiverModeCode;
   } scl_cfg_t;

endpackage

// ===== core/scl_channel_clock_line.sv
// One serial channel's clock routing, line-mode and byte-order logic.
`timescale 1ns/1ps

// Notes on behaviour
// - Transmit bits launch on rising clock edge, falling when invert set.
// - Receive bits sampled on falling clock edge, rising when invert set.
// - Receiver clock: baud output, receive line, DPLL; code 11 reserved.
// - Transmitter clock: baud, rx/tx lines, DPLL, baud/16; rest reserved.
// - Baud clock: three oscillators, rx line, tx line; rest reserved.
// - Transmit-clock-on-RTS bit routes the transmit clock onto RTS.
// - Three-bit mode field drives transceivers; resets to high impedance.
// - Mode codes map to line standards; 111 is all lines high impedance.
// - Single-ended V.28 mode uses only A-side conductors, B-side unused.
// - Host accesses little endian, byte 0 on lowest byte lane.
// - Lower-addressed transmit bytes are serialized first.
// - Earlier received bytes are placed at lower byte positions.
module scl_channel_clock_line #(
   parameter int CHANNEL = 0
) (
   input wire logic core_clk, // System clock, 40 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic regWrEn, // Register write strobe.
   input wire logic regRdEn, // Register read strobe.
   input wire logic [11:0] regAddr, // Register byte address.
   input wire logic [3:0] regByteEn, // Byte lane enables.
   input wire logic [31:0] regWrData, // Write data.
   output logic [31:0] regRdData, // Read data, registered.
   output logic regRdValid, // Read data valid pulse.
   input wire logic osc1Pin, // Oscillator one level.
   input wire logic osc2Pin, // Oscillator two level.
   input wire logic osc3Pin, // Oscillator three level.
   input wire logic rxClkLine, // External receive clock pin.
   input wire logic txClkLine, // External transmit clock pin.
   input wire logic rxdLine, // Receive data pin, A side.
   input wire logic dpllRxClk, // DPLL receive clock level.
   input wire logic dpllTxClk, // DPLL transmit clock level.
   input wire logic baudGenOut, // Baud generator output level.
   output logic baudGenClk, // Selected baud generator input clock.
   input wire logic rtsRequest, // Normal request-to-send level.
   input wire logic [31:0] txWord, // Transmit data word.
   input wire logic txWordValid, // Transmit word offered.
   output logic txWordReady, // Serializer can take a word.
   output logic [31:0] rxWord, // Packed receive word.
   output logic rxWordValid, // Receive word pulse.
   output scl_pkg::scl_cfg_t cfgFields, // Decoded configuration.
   output logic [2:0] transceiverModeCode, // Transceiver mode inputs.
   output logic txdA, // Transmit data A side.
   output logic txdB, // Transmit data B side.
   output logic txdAOeN, // A-side driver enable, low drives.
   output logic txdBOeN, // B-side driver enable, low drives.
   output logic rtsA, // RTS A side.
   output logic rtsB, // RTS B side.
   output logic rtsAOeN, // RTS A enable, low drives.
   output logic rtsBOeN // RTS B enable, low drives.
);
   import scl_pkg::*;

   localparam logic [11:0] CFG_OFFSET = 12'(CFG_BASE_OFFSET +
      CFG_CHANNEL_STRIDE * CHANNEL);

   // Merge write data under byte enables; lane 0 carries bits 7:0.
   function automatic logic [31:0] mergeLanes(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   logic [31:0] cfgReg;
   logic [31:0] next_cfgReg;
   logic cfgHit;
   logic [PIN_COUNT-1:0] pinMeta;
   logic [PIN_COUNT-1:0] pinSync;
   logic [PIN_COUNT-1:0] pinLive;
   logic rxClkSel;
   logic txClkSel;
   logic rxClkPrev;
   logic txClkPrev;
   logic baudPrev;
   logic [2:0] div16Count;
   logic baudDiv16;
   logic txLaunch;
   logic rxSample;
   logic [31:0] txShift;
   logic [4:0] txCount;
   logic txBusy;
   logic txBit;
   logic [31:0] rxShift;
   logic [4:0] rxCount;
   logic diffDataUsed;
   logic diffCtrlUsed;
   logic linesLive;
   logic rtsLevel;

   // Register decode; bytes follow PCI lane order.
   // Little endian lanes.
   assign cfgHit = (regAddr == CFG_OFFSET);
   assign next_cfgReg = mergeLanes(cfgReg, regWrData, regByteEn) &
      CFG_WRITE_MASK;

   // Configuration register with its single write path.
   // Mode resets high-Z.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfgReg <= CFG_RESET;
      end else if (regWrEn && cfgHit) begin
         cfgReg <= next_cfgReg;
      end
   end

   // Reads answer one cycle later; an unmapped address reads as zero.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regRdData <= 32'h00000000;
         regRdValid <= 1'b0;
      end else begin
         regRdData <= (regRdEn && cfgHit) ? cfgReg : 32'h00000000;
         regRdValid <= regRdEn;
      end
   end

   // Field view of the register.
   assign cfgFields.rxClockInvert = cfgReg[RX_INV_BIT];
   assign cfgFields.txClockInvert = cfgReg[TX_INV_BIT];
   assign cfgFields.receiverClockSelect = cfgReg[RCS_LSB +: 2];
   assign cfgFields.transmitterClockSelect = cfgReg[TCS_LSB +: 3];
   assign cfgFields.baudGenClockSelect = cfgReg[BCS_LSB +: 3];
   assign cfgFields.txClockOnRts = cfgReg[RTS_CLK_BIT];
   assign cfgFields.transceiverModeCode = cfgReg[MODE_LSB +: 3];

   // Pins from outside pass two flops; only the second stage is read.
   // Sampling at 40 MHz resolves line clocks well below half that rate.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pinMeta <= '0;
         pinSync <= '0;
      end else begin
         pinMeta <= {rxdLine, txClkLine, rxClkLine, osc3Pin, osc2Pin,
            osc1Pin};
         pinSync <= pinMeta;
      end
   end
   assign pinLive = pinSync;

   // Baud generator source select.
   // Baud clock mux.
   always_comb begin
      unique case (cfgFields.baudGenClockSelect)
         BCS_OSC1: baudGenClk = pinLive[PIN_OSC1];
         BCS_OSC2: baudGenClk = pinLive[PIN_OSC2];
         BCS_OSC3: baudGenClk = pinLive[PIN_OSC3];
         BCS_RX_LINE: baudGenClk = pinLive[PIN_RX_CLK];
         BCS_TX_LINE: baudGenClk = pinLive[PIN_TX_CLK];
         default: baudGenClk = 1'b0;
      endcase
   end

   // Receiver clock source select.
   // Receive clock mux.
   always_comb begin
      unique case (cfgFields.receiverClockSelect)
         RCS_BAUD: rxClkSel = baudGenOut;
         RCS_RX_LINE: rxClkSel = pinLive[PIN_RX_CLK];
         RCS_DPLL: rxClkSel = dpllRxClk;
         default: rxClkSel = 1'b0;
      endcase
   end

   // Transmitter clock source select; the line source assumes the
   // transmit clock pin is an input, which software must ensure.
   // Transmit clock mux.
   always_comb begin
      unique case (cfgFields.transmitterClockSelect)
         TCS_BAUD: txClkSel = baudGenOut;
         TCS_RX_LINE: txClkSel = pinLive[PIN_RX_CLK];
         TCS_TX_LINE: txClkSel = pinLive[PIN_TX_CLK];
         TCS_DPLL: txClkSel = dpllTxClk;
         TCS_BAUD_DIV16: txClkSel = baudDiv16;
         default: txClkSel = 1'b0;
      endcase
   end

   // Divide the baud output by 16 on its rising edges.
   // Divide by 16.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         baudPrev <= 1'b0;
         div16Count <= 3'h0;
         baudDiv16 <= 1'b0;
      end else begin
         baudPrev <= baudGenOut;
         if (baudGenOut && !baudPrev) begin
            div16Count <= div16Count + 3'h1;
            if (div16Count == DIV16_HALF_LAST) begin
               baudDiv16 <= ~baudDiv16;
            end
         end
      end
   end

   // Previous clock levels for edge enables.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxClkPrev <= 1'b0;
         txClkPrev <= 1'b0;
      end else begin
         rxClkPrev <= rxClkSel;
         txClkPrev <= txClkSel;
      end
   end

   // Edge choice by polarity.
   // Launch edge select.
   assign txLaunch = cfgFields.txClockInvert ? (txClkPrev && !txClkSel) :
      (!txClkPrev && txClkSel);
   assign rxSample = cfgFields.rxClockInvert ? (!rxClkPrev && rxClkSel) :
      (rxClkPrev && !rxClkSel);

   // Serializer takes a new word only when idle.
   assign txWordReady = !txBusy;

   // Shifting right sends byte 0 first, each byte LSB first; the line
   // holds the last bit sent between words; it is mark only after reset.
   // Low bytes first.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         txShift <= 32'h00000000;
         txCount <= 5'h00;
         txBusy <= 1'b0;
         txBit <= 1'b1;
      end else if (!txBusy) begin
         if (txWordValid) begin
            txShift <= txWord;
            txCount <= 5'h00;
            txBusy <= 1'b1;
         end
      end else if (txLaunch) begin
         txBit <= txShift[0];
         txShift <= {1'b0, txShift[31:1]};
         txCount <= txCount + 5'h01;
         if (txCount == WORD_LAST_BIT) begin
            txBusy <= 1'b0;
         end
      end
   end

   // New bits enter at the top, so the first bit ends at bit 0.
   // Early bytes low.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rxShift <= 32'h00000000;
         rxCount <= 5'h00;
         rxWord <= 32'h00000000;
         rxWordValid <= 1'b0;
      end else begin
         rxWordValid <= 1'b0;
         if (rxSample) begin
            rxShift <= {pinLive[PIN_RXD], rxShift[31:1]};
            rxCount <= rxCount + 5'h01;
            if (rxCount == WORD_LAST_BIT) begin
               rxWord <= {pinLive[PIN_RXD], rxShift[31:1]};
               rxWordValid <= 1'b1;
            end
         end
      end
   end

   // Transceiver mode straight from the register.
   // Drive mode inputs.
   assign transceiverModeCode = cfgFields.transceiverModeCode;

   // Which conductors each mode uses; V.35 keeps control single ended.
   // Mode mapping.
   assign linesLive = (cfgFields.transceiverModeCode != MODE_HIGH_Z);
   assign diffDataUsed = linesLive &&
      (cfgFields.transceiverModeCode != MODE_V28);
   assign diffCtrlUsed = diffDataUsed &&
      (cfgFields.transceiverModeCode != MODE_V35);

   // RTS carries the transmit clock when asked.
   // Clock onto RTS.
   assign rtsLevel = cfgFields.txClockOnRts ? txClkSel : rtsRequest;

   // Line outputs; enables are low while driving.
   assign txdA = txBit;
   assign txdB = ~txBit;
   assign txdAOeN = !linesLive;
   assign txdBOeN = !diffDataUsed;
   assign rtsA = rtsLevel;
   assign rtsB = ~rtsLevel;
   assign rtsAOeN = !linesLive;
   assign rtsBOeN = !diffCtrlUsed;

endmodule // scl_channel_clock_line

// ===== verification/scl_line_chk.sv
// Property checker for one channel's clock and line configuration.
`timescale 1ns/1ps
module scl_line_chk (
   input wire logic core_clk, // System clock.
   input wire logic rst, // Reset, high.
   input wire logic regRdEn, // Read strobe.
   input wire logic [31:0] regRdData, // Read data.
   input wire logic regRdValid, // Read valid.
   input wire logic baudGenClk, // Baud clock.
   input wire logic rtsRequest, // RTS level.
   input wire logic txWordValid, // Word offered.
   input wire logic txWordReady, // Serializer free.
   input wire logic rxWordValid, // Word pulse.
   input wire scl_pkg::scl_cfg_t cfgFields, // Fields.
   input wire logic [2:0] transceiverModeCode, // Mode pins.
   input wire logic txdAOeN, // Enable.
   input wire logic txdBOeN, // Enable.
   input wire logic rtsA, // RTS A side.
   input wire logic rtsAOeN, // Enable.
   input wire logic rtsBOeN // Enable.
);
   import scl_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Driver enables packed as txdA, txdB, rtsA, rtsB; low drives.
   wire logic [3:0] oeN = {txdAOeN, txdBOeN, rtsAOeN, rtsBOeN};

   a_mode_pins_follow: assert property (
      transceiverModeCode == cfgFields.transceiverModeCode)
      else $error("mode pins differ from field");
   a_hiz_all_off: assert property (
      transceiverModeCode == MODE_HIGH_Z |-> oeN == 4'hf)
      else $error("driver on in high impedance");
   a_single_end_a: assert property (
      transceiverModeCode == MODE_V28 |-> oeN == 4'h5)
      else $error("single ended mode uses wrong side");
   a_v35_rts_a: assert property (
      transceiverModeCode == MODE_V35 |-> oeN == 4'h1)
      else $error("mixed mode uses wrong side");
   // A registered RTS path is allowed, so the level must have settled.
   a_rts_normal: assert property (
      (!cfgFields.txClockOnRts && $stable(rtsRequest)) [*2]
      |-> rtsA == rtsRequest)
      else $error("rts does not follow request");
   a_read_answer: assert property (
      regRdEn |=> regRdValid && regRdData[31:22] == 10'h0)
      else $error("read answer missing or reserved bits set");
   a_reserved_gated: assert property (
      cfgFields.baudGenClockSelect > BCS_TX_LINE |-> !baudGenClk)
      else $error("reserved baud source passes a clock");
   a_tx_take_busy: assert property (
      txWordValid && txWordReady |=> !txWordReady [*8])
      else $error("serializer free too soon");
   a_rx_pulse_one: assert property (
      rxWordValid |=> !rxWordValid [*8])
      else $error("receive words too close");
   c_mode_v28: cover property (transceiverModeCode == MODE_V28);
   c_tx_taken: cover property (txWordValid && txWordReady);
   c_rx_word: cover property (rxWordValid);
endmodule // scl_line_chk

bind scl_channel_clock_line scl_line_chk scl_line_chk_inst (.core_clk, .rst,
   .regRdEn, .regRdData, .regRdValid, .baudGenClk, .rtsRequest,
   .txWordValid, .txWordReady, .rxWordValid, .cfgFields,
   .transceiverModeCode, .txdAOeN, .txdBOeN, .rtsA, .rtsAOeN, .rtsBOeN);

// ===== verification/scl_line_partner.sv
// Behavioural model of the line transceivers and remote equipment.
`timescale 1ns/1ps
module scl_line_partner (
   input wire logic txd, // Transmit data, A side.
   output logic rxClk, // Receive clock line.
   output logic txClk, // Transmit clock line.
   output logic rxd // Receive data line.
);
   logic base = 1'h0;
   logic [1:0] inv = 2'h0;
   logic [31:0] cap = 32'h0;
   logic rxdLevel = 1'h1;
   // The clock stands still between frames; inv sets each line's level.
   assign rxClk = base ^ inv[0];
   // The transmit clock pin is only ever driven from this side.
   assign txClk = base ^ inv[1];
   assign rxd = rxdLevel;
   // One frame of 32 bits, half period h core cycles.
   task automatic frame(input logic [31:0] w, input int h);
      for (int i = 0; i < 32; i++) begin
         base = 1'h1;
         rxdLevel = w[i];
         #(h * 25);
         base = 1'h0;
         cap = {txd, cap[31:1]};
         #(h * 25);
      end
      // A released line shows the inverse of the last bit.
      rxdLevel = ~w[31];
   endtask
endmodule // scl_line_partner

// ===== verification/scl_channel_clock_line_tb.sv
// Self-checking bench for one channel's clock and line configuration.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   cmpCount++; \
   if ((got) !== (exp)) begin \
      mismatches++; \
      $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
   end \
end
module scl_channel_clock_line_tb;
   import scl_pkg::*;
   localparam logic [11:0] ADDR = CFG_BASE_OFFSET + CFG_CHANNEL_STRIDE;
   logic core_clk = 1'h0, rst = 1'h1, regWrEn = 1'h0, regRdEn = 1'h0;
   logic [11:0] regAddr = 12'h0;
   logic [3:0] regByteEn = 4'h0;
   logic [31:0] regWrData = 32'h0, txWord = 32'h0;
   logic [2:0] osc = 3'h0;
   logic baudGenOut = 1'h0, rtsRequest = 1'h0, txWordValid = 1'h0;
   logic dpllRx = 1'h0, dpllTx = 1'h0;
   logic [31:0] regRdData, rxWord, rxGot;
   logic regRdValid, baudGenClk, txWordReady, rxWordValid, txdA, txdB;
   logic txdAOeN, txdBOeN, rtsA, rtsB, rtsAOeN, rtsBOeN;
   logic rxClkLine, txClkLine, rxdLine;
   logic [2:0] transceiverModeCode;
   scl_cfg_t cfgFields;
   int mismatches = 0, cmpCount = 0, rxCnt = 0;

   scl_channel_clock_line #(.CHANNEL(1)) scl_channel_clock_line_inst (
      .core_clk, .rst, .regWrEn, .regRdEn, .regAddr, .regByteEn,
      .regWrData, .regRdData, .regRdValid, .osc1Pin(osc[0]),
      .osc2Pin(osc[1]), .osc3Pin(osc[2]), .rxClkLine, .txClkLine,
      .rxdLine, .dpllRxClk(dpllRx), .dpllTxClk(dpllTx), .baudGenOut,
      .baudGenClk, .rtsRequest, .txWord, .txWordValid, .txWordReady,
      .rxWord, .rxWordValid, .cfgFields, .transceiverModeCode, .txdA,
      .txdB, .txdAOeN, .txdBOeN, .rtsA, .rtsB, .rtsAOeN, .rtsBOeN);
   scl_line_partner scl_line_partner_inst (.txd(txdA), .rxClk(rxClkLine),
      .txClk(txClkLine), .rxd(rxdLine));

   // 40 MHz core clock.
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   // Catch receive words; the valid flag stands for one cycle only.
   always @(posedge core_clk) begin
      if (rxWordValid === 1'h1) begin
         rxGot <= rxWord;
         rxCnt <= rxCnt + 1;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] be);
      @(negedge core_clk);
      regWrEn = 1'h1;
      regAddr = a;
      regWrData = d;
      regByteEn = be;
      tick(1);
      regWrEn = 1'h0;
   endtask
   // The answer stands for one cycle, so it is looked at right then.
   task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
      @(negedge core_clk);
      regRdEn = 1'h1;
      regAddr = a;
      tick(1);
      regRdEn = 1'h0;
      `CHK(regRdValid, 1'h1)
      `CHK(regRdData, e)
   endtask
   task automatic chkReset();
      rdChk(ADDR, 32'h00000007);
      `CHK({txdAOeN, txdBOeN, rtsAOeN, rtsBOeN}, 4'hf)
   endtask
   // Byte lanes, reserved bits and an unmapped neighbour.
   task automatic regLanes();
      wr(ADDR, 32'hffffffff, 4'h1);
      rdChk(ADDR, 32'h000000ff);
      wr(ADDR, 32'hffffffff, 4'h4);
      rdChk(ADDR, 32'h003f00ff);
      `CHK(cfgFields, 14'h00ff)
      rdChk(ADDR + 12'h4, 32'h0);
      wr(ADDR + 12'h4, 32'h3, 4'hf);
      rdChk(ADDR, 32'h003f00ff);
   endtask
   task automatic modeScan();
      logic [3:0] oe [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h5, 4'hf};
      for (int m = 0; m < 8; m++) begin
         rtsRequest = m[0];
         wr(ADDR, 32'(m), 4'hf);
         tick(1);
         `CHK(transceiverModeCode, m[2:0])
         `CHK({txdAOeN, txdBOeN, rtsAOeN, rtsBOeN}, oe[m])
         `CHK(rtsA, m[0])
         `CHK(rtsB, !m[0])
         `CHK({txdA, txdB}, 2'h2)
      end
   endtask
   // Every baud source code, with only that source's pin raised for codes 0 to 4.
   task automatic baudMux();
      for (int c = 0; c < 8; c++) begin
         wr(ADDR, 32'(c) << 4, 4'hf);
         // Reserved codes see every source raised, so a leak would show.
         osc = (c < 3) ? 3'h1 << c : ((c > 4) ? 3'h7 : 3'h0);
         // The transmit line is an input here.
         scl_line_partner_inst.inv = (c > 4) ? 2'h3 : {c == 4, c == 3};
         tick(5);
         `CHK(baudGenClk, c < 5)
         osc = 3'h0;
         scl_line_partner_inst.inv = 2'h0;
         tick(5);
         `CHK(baudGenClk, 1'h0)
      end
   endtask
   task automatic rtsClock();
      rtsRequest = 1'h0;
      wr(ADDR, 32'h108, 4'hf);
      scl_line_partner_inst.inv = 2'h2;
      tick(5);
      `CHK(rtsA, 1'h1)
      scl_line_partner_inst.inv = 2'h0;
      tick(5);
      `CHK(rtsA, 1'h0)
   endtask
   // Every transmit source but baud/16 seen on RTS; the receiver stays on the idle
   // DPLL clock so that baud pulses add no receive samples.
   task automatic txMux();
      for (int c = 0; c < 8; c++) begin
         wr(ADDR, (32'(c) << 7) | 32'h808, 4'hf);
         baudGenOut = (c == 0) || (c > 4);
         scl_line_partner_inst.inv = (c > 4) ? 2'h3 : {c == 2, c == 1};
         dpllTx = (c == 3) || (c > 4);
         tick(5);
         `CHK(rtsA, c < 4)
         baudGenOut = 1'h0;
         scl_line_partner_inst.inv = 2'h0;
         dpllTx = 1'h0;
         tick(5);
         `CHK(rtsA, 1'h0)
      end
   endtask
   // One word each way over the line clocks at the given polarity.
   task automatic frameRun(input logic [31:0] cfg, input logic [1:0] pol,
         input logic [31:0] tw, input logic [31:0] rw, input int h);
      int n;
      // Idle levels settle first, so a polarity change adds no edge.
      scl_line_partner_inst.inv = pol;
      tick(4);
      wr(ADDR, cfg, 4'hf);
      n = rxCnt;
      tick(4);
      txWord = tw;
      txWordValid = 1'h1;
      tick(1);
      txWordValid = 1'h0;
      `CHK(txWordReady, 1'h0)
      scl_line_partner_inst.frame(rw, h);
      tick(8);
      `CHK(scl_line_partner_inst.cap, tw)
      `CHK(txWordReady, 1'h1)
      `CHK(rxCnt - n, 32'h1)
      `CHK(rxGot, rw)
   endtask
   // Pulses the DPLL and line receive clocks 32 times with alternating data.
   task automatic rxPulses();
      for (int i = 0; i < 32; i++) begin
         scl_line_partner_inst.rxdLevel = i[0];
         dpllRx = 1'h1;
         scl_line_partner_inst.inv = 2'h1;
         tick(4);
         dpllRx = 1'h0;
         scl_line_partner_inst.inv = 2'h0;
         tick(4);
      end
   endtask
   // Receive sources after a second reset: the DPLL clock fills one word,
   // then the reserved code must let no sample through.
   task automatic rxMux();
      int n;
      rst = 1'h1;
      tick(2);
      rst = 1'h0;
      `CHK({txdA, txWordReady, rxWordValid}, 3'h6)
      rdChk(ADDR, 32'h00000007);
      wr(ADDR, 32'h800, 4'hf);
      n = rxCnt;
      rxPulses();
      tick(4);
      `CHK(rxCnt - n, 32'h1)
      `CHK(rxGot, 32'haaaaaaaa)
      wr(ADDR, 32'hc00, 4'hf);
      rxPulses();
      tick(4);
      `CHK(rxCnt - n, 32'h1)
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         baudGenOut = 1'h1;
         tick(2);
         baudGenOut = 1'h0;
         tick(2);
      end
   endtask
   // Divided baud clock: first rise after 8 baud rises, then every 16.
   task automatic div16();
      wr(ADDR, 32'h200, 4'hf);
      scl_line_partner_inst.inv = 2'h0;
      txWord = 32'h2;
      txWordValid = 1'h1;
      tick(1);
      txWordValid = 1'h0;
      pulses(8);
      `CHK(txdA, 1'h0)
      pulses(15);
      `CHK(txdA, 1'h0)
      pulses(1);
      `CHK(txdA, 1'h1)
      pulses(481);
      `CHK(txWordReady, 1'h1)
   endtask
   task automatic printVerdict();
      if (mismatches == 0 && cmpCount > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // A hang counts as a mismatch and ends the run.
   initial begin
      repeat (40000) @(posedge core_clk);
      mismatches++;
      printVerdict();
   end
   // Reset for 20 cycles, then the scenarios in an order that keeps the
   // free-running receive count aligned to the first frame.
   initial begin
      tick(20);
      rst = 1'h0;
      chkReset();
      regLanes();
      modeScan();
      baudMux();
      rtsClock();
      txMux();
      frameRun(32'h500, 2'h0, 32'h1234a5c3, 32'h96e10f3b, 10);
      frameRun(32'h3500, 2'h3, 32'h5a0f8421, 32'hc3a51e87, 8);
      // A second reset clears the divider and receive count for the rest.
      rxMux();
      div16();
      printVerdict();
   end
endmodule // scl_channel_clock_line_tb
